// ==== rtl/output_fault_channel.sv ====
// Fault supervision of one switch output
`timescale 1ns/1ps
module output_fault_channel #(
  parameter int SHORT_CYC = fault_sup_pkg::SHORT_CYC
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_clear,
  input wire logic i_cmd_on,
  input wire logic i_open_cmp,
  input wire logic i_vds_high,
  input wire logic i_ilim,
  input wire logic i_overtemp,
  input wire logic i_filter_done,
  input wire logic i_fssd,
  input wire logic i_retry,
  input wire logic i_pulldn_en,
  output logic o_drive,
  output fault_sup_pkg::ch_evt_t o_evt
);

  // ----------------------------------------
  // Short timer
  // ----------------------------------------
  localparam logic [fault_sup_pkg::CNT_W-1:0] SHORT_LAST = fault_sup_pkg::CNT_W'(SHORT_CYC - 1);
  fault_sup_pkg::ch_state_t state_r;
  fault_sup_pkg::ch_state_t state_nxt;
  logic [fault_sup_pkg::CNT_W-1:0] short_cnt_r;
  logic short_cond;
  logic short_trip;
  logic drive_r;

  assign short_cond = (state_r == fault_sup_pkg::CH_RUN) && i_cmd_on && !i_fssd && i_ilim && i_vds_high;
  assign short_trip = short_cond && (short_cnt_r == SHORT_LAST);

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      short_cnt_r <= '0;
    end else if (i_clear || !short_cond) begin
      short_cnt_r <= '0;
    end else if (!short_trip) begin
      short_cnt_r <= short_cnt_r + 1'b1;
    end
  end

  // ----------------------------------------
  // Protection state
  // ----------------------------------------
  always_comb begin
    state_nxt = state_r;
    case (state_r)
      fault_sup_pkg::CH_RUN: begin
        if (i_overtemp) begin
          state_nxt = fault_sup_pkg::CH_HOT;
        end else if (short_trip) begin
          state_nxt = fault_sup_pkg::CH_LOCKED;
        end
      end
      fault_sup_pkg::CH_HOT: begin
        // Stays off until cooled; retry repeats while the fault persists
        if (!i_overtemp) begin
          if (i_retry || !i_cmd_on) begin
            state_nxt = fault_sup_pkg::CH_RUN;
          end else begin
            state_nxt = fault_sup_pkg::CH_LOCKED;
          end
        end
      end
      fault_sup_pkg::CH_LOCKED: begin
        if (!i_cmd_on && !i_overtemp) begin
          state_nxt = fault_sup_pkg::CH_RUN;
        end
      end
      default: begin
        state_nxt = fault_sup_pkg::CH_RUN;
      end
    endcase
    if (i_clear) begin
      state_nxt = fault_sup_pkg::CH_RUN;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      state_r <= fault_sup_pkg::CH_RUN;
    end else begin
      state_r <= state_nxt;
    end
  end

  always_ff @(posedge i_clk or negedge i_rst_n) begin
    if (!i_rst_n) begin
      drive_r <= 1'b0;
    end else begin
      drive_r <= !i_clear && i_cmd_on && (state_nxt == fault_sup_pkg::CH_RUN);
    end
  end

  assign o_drive = drive_r;

  // ----------------------------------------
  // Events
  // ----------------------------------------
  // Open load is only judged while off, pull-down on and the filter has run out
  assign o_evt.open_f = !i_clear && !i_cmd_on && i_pulldn_en && i_filter_done && i_open_cmp;
  assign o_evt.short_f = !i_clear && short_trip && !i_overtemp;
  assign o_evt.therm_f = !i_clear && (state_r == fault_sup_pkg::CH_RUN) && i_overtemp;

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_short_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    (short_trip && !i_clear && !i_overtemp) |=> (!o_drive && state_r == fault_sup_pkg::CH_LOCKED);
  endproperty
  a_short_off: assert property (p_short_off) else $error("short did not shut output");

  property p_hot_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == fault_sup_pkg::CH_HOT) |-> !o_drive;
  endproperty
  a_hot_off: assert property (p_hot_off) else $error("hot output driven");

  property p_no_retry;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == fault_sup_pkg::CH_HOT && !i_overtemp && !i_retry && i_cmd_on && !i_clear)
      |=> (state_r == fault_sup_pkg::CH_LOCKED && !o_drive);
  endproperty
  a_no_retry: assert property (p_no_retry) else $error("output left latch-off");

  property p_retry;
    @(posedge i_clk) disable iff (!i_rst_n)
    (state_r == fault_sup_pkg::CH_HOT && !i_overtemp && i_retry && i_cmd_on && !i_clear) |=> o_drive;
  endproperty
  a_retry: assert property (p_retry) else $error("retry did not restart");

  property p_open_off;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_evt.open_f |-> (!i_cmd_on && i_filter_done && i_pulldn_en);
  endproperty
  a_open_off: assert property (p_open_off) else $error("open load flagged while on");

endmodule : output_fault_channel

// ==== rtl/output_fault_supervisor.sv ====
// Fault supervisor for sixteen low-side outputs with status word and register port
//
// Functional notes
// - Open load is checked only while an output is commanded off, per output.
// - Pull-down sources are off after reset; open-load detection needs them enabled.
// - An enabled pull-down turns off only on undervoltage or by software write.
// - Open-load indications are suppressed during a filter interval after chip-select release.
// - Chip-select rising edge restarts the delay timer; open-load comparators ignored until expiry.
// - An open-load fault stays latched in the status word until read.
// - With fast-short disable clear, output shuts after VDS high in limit for 450 us.
// - Thermal limit shuts only that output; it stays off until cooled.
// - Under retry, thermal shutdown and restart repeat until cleared or commanded off.
// - Current limit, fast short and thermal events set global fault bit 23.
// - Serial output supply undervoltage turns outputs off and resets control registers.
// - Main supply undervoltage turns outputs off and resets the device.
// - Thermal shutdown leaves other outputs alone; after cooling follows global bit 17.
// - All fault bits clear on the chip-select rising edge ending a transfer; a fault present in that cycle sets its bit again.
// - Bit 17 low keeps cooled outputs off; high lets them retry.
// - Status bits 15 to 0 report per-output faults, one meaning fault.
`timescale 1ns/1ps
module output_fault_supervisor #(
  parameter int FILTER_CYC = fault_sup_pkg::FILTER_CYC,
  parameter int SHORT_CYC = fault_sup_pkg::SHORT_CYC
) (
  input wire logic I_REF_CLK,
  input wire logic I_RESET_N,
  input wire logic I_CS_N,
  input wire logic I_SERIAL_OUTPUT_SUPPLY_UV,
  input wire logic I_MAIN_UV,
  input wire logic [fault_sup_pkg::NUM_OUT-1:0] I_CMD_ON,
  input wire logic [fault_sup_pkg::NUM_OUT-1:0] I_OPEN_CMP,
  input wire logic [fault_sup_pkg::NUM_OUT-1:0] I_VDS_HIGH,
  input wire logic [fault_sup_pkg::NUM_OUT-1:0] I_ILIM,
  input wire logic [fault_sup_pkg::NUM_OUT-1:0] I_OVERTEMP,
  input wire logic [fault_sup_pkg::ADDR_W-1:0] I_ADDR,
  input wire logic [fault_sup_pkg::DATA_W-1:0] I_WDATA,
  input wire logic I_WR,
  input wire logic I_RD,
  output logic [fault_sup_pkg::DATA_W-1:0] O_RDATA,
  output logic [fault_sup_pkg::NUM_OUT-1:0] O_SWITCH_OUTPUTS,
  output logic [fault_sup_pkg::NUM_OUT-1:0] O_PULLDN_EN,
  output logic [fault_sup_pkg::SO_W-1:0] O_STATUS_WORD,
  output logic O_IRQ
);

  localparam logic [fault_sup_pkg::CNT_W-1:0] FILTER_LAST = fault_sup_pkg::CNT_W'(FILTER_CYC);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  // Comparator, supply monitor and chip-select pins are asynchronous; all of them pass two flops
  fault_sup_pkg::pins_t pins_meta_r;
  fault_sup_pkg::pins_t pins_r;
  fault_sup_pkg::pins_t pins_in;
  logic cs_n_d_r;
  logic cs_rise;

  assign pins_in.cs_n = I_CS_N;
  assign pins_in.serial_output_supply_uv = I_SERIAL_OUTPUT_SUPPLY_UV;
  assign pins_in.main_uv = I_MAIN_UV;
  assign pins_in.open_cmp = I_OPEN_CMP;
  assign pins_in.vds_high = I_VDS_HIGH;
  assign pins_in.ilim = I_ILIM;
  assign pins_in.overtemp = I_OVERTEMP;

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      // Chip select idles high; a low reset value would fake an edge after reset
      pins_meta_r <= '0;
      pins_meta_r.cs_n <= 1'b1;
      pins_r <= '0;
      pins_r.cs_n <= 1'b1;
    end else begin
      pins_meta_r <= pins_in;
      pins_r <= pins_meta_r;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      cs_n_d_r <= 1'b1;
    end else begin
      cs_n_d_r <= pins_r.cs_n;
    end
  end

  assign cs_rise = pins_r.cs_n && !cs_n_d_r;

  // ----------------------------------------
  // Undervoltage handling
  // ----------------------------------------
  logic dev_clear;
  logic ctrl_clear;

  assign dev_clear = pins_r.main_uv;
  assign ctrl_clear = pins_r.serial_output_supply_uv || pins_r.main_uv;

  // ----------------------------------------
  // Fault delay timer
  // ----------------------------------------
  logic [fault_sup_pkg::CNT_W-1:0] filt_cnt_r;
  logic filter_done;

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      filt_cnt_r <= '0;
    end else if (cs_rise || dev_clear) begin
      filt_cnt_r <= '0;
    end else if (filt_cnt_r != FILTER_LAST) begin
      filt_cnt_r <= filt_cnt_r + 1'b1;
    end
  end

  assign filter_done = (filt_cnt_r == FILTER_LAST);

  // ----------------------------------------
  // Register port
  // ----------------------------------------
  logic [fault_sup_pkg::NUM_OUT-1:0] pulldn_r;
  logic [fault_sup_pkg::NUM_OUT-1:0] fssd_r;
  logic retry_r;
  logic [fault_sup_pkg::IRQ_W-1:0] mask_r;
  logic [fault_sup_pkg::IRQ_W-1:0] irq_st_r;
  logic [fault_sup_pkg::IRQ_W-1:0] irq_set;
  logic [fault_sup_pkg::DATA_W-1:0] rdata_r;
  logic [fault_sup_pkg::NUM_OUT-1:0] fault_r;
  logic glob_r;
  logic [fault_sup_pkg::SO_W-1:0] so_word;

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      pulldn_r <= fault_sup_pkg::PULLDN_RST;
    end else if (ctrl_clear) begin
      pulldn_r <= fault_sup_pkg::PULLDN_RST;
    end else if (I_WR && I_ADDR == fault_sup_pkg::OFS_PULLDN) begin
      pulldn_r <= I_WDATA[fault_sup_pkg::NUM_OUT-1:0];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fssd_r <= fault_sup_pkg::FSSD_RST;
    end else if (ctrl_clear) begin
      fssd_r <= fault_sup_pkg::FSSD_RST;
    end else if (I_WR && I_ADDR == fault_sup_pkg::OFS_FSSD) begin
      fssd_r <= I_WDATA[fault_sup_pkg::NUM_OUT-1:0];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      retry_r <= fault_sup_pkg::RETRY_RST;
    end else if (ctrl_clear) begin
      retry_r <= fault_sup_pkg::RETRY_RST;
    end else if (I_WR && I_ADDR == fault_sup_pkg::OFS_GLOBAL) begin
      retry_r <= I_WDATA[fault_sup_pkg::RETRY_BIT];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      mask_r <= fault_sup_pkg::MASK_RST;
    end else if (ctrl_clear) begin
      mask_r <= fault_sup_pkg::MASK_RST;
    end else if (I_WR && I_ADDR == fault_sup_pkg::OFS_IRQ_MASK) begin
      mask_r <= I_WDATA[fault_sup_pkg::IRQ_W-1:0];
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      rdata_r <= '0;
    end else if (I_RD) begin
      case (I_ADDR)
        fault_sup_pkg::OFS_PULLDN: rdata_r <= {{(fault_sup_pkg::DATA_W-fault_sup_pkg::NUM_OUT){1'b0}}, pulldn_r};
        fault_sup_pkg::OFS_FSSD: rdata_r <= {{(fault_sup_pkg::DATA_W-fault_sup_pkg::NUM_OUT){1'b0}}, fssd_r};
        fault_sup_pkg::OFS_GLOBAL: begin
          rdata_r <= '0;
          rdata_r[fault_sup_pkg::RETRY_BIT] <= retry_r;
        end
        fault_sup_pkg::OFS_STATUS: rdata_r <= {{(fault_sup_pkg::DATA_W-fault_sup_pkg::SO_W){1'b0}}, so_word};
        fault_sup_pkg::OFS_IRQ_ST: rdata_r <= {{(fault_sup_pkg::DATA_W-fault_sup_pkg::IRQ_W){1'b0}}, irq_st_r};
        fault_sup_pkg::OFS_IRQ_MASK: rdata_r <= {{(fault_sup_pkg::DATA_W-fault_sup_pkg::IRQ_W){1'b0}}, mask_r};
        default: rdata_r <= '0;
      endcase
    end else begin
      rdata_r <= '0;
    end
  end

  // ----------------------------------------
  // Output channels
  // ----------------------------------------
  logic [fault_sup_pkg::NUM_OUT-1:0] drive;
  logic [fault_sup_pkg::NUM_OUT-1:0] ev_open;
  logic [fault_sup_pkg::NUM_OUT-1:0] ev_short;
  logic [fault_sup_pkg::NUM_OUT-1:0] ev_therm;
  logic [fault_sup_pkg::NUM_OUT-1:0] fault_set;

  genvar g;
  generate
    for (g = 0; g < fault_sup_pkg::NUM_OUT; g++) begin : g_ch
      fault_sup_pkg::ch_evt_t evt;
      output_fault_channel #(
        .SHORT_CYC(SHORT_CYC)
      ) u_ch (
        .i_clk(I_REF_CLK),
        .i_rst_n(I_RESET_N),
        .i_clear(ctrl_clear),
        .i_cmd_on(I_CMD_ON[g]),
        .i_open_cmp(pins_r.open_cmp[g]),
        .i_vds_high(pins_r.vds_high[g]),
        .i_ilim(pins_r.ilim[g]),
        .i_overtemp(pins_r.overtemp[g]),
        .i_filter_done(filter_done),
        .i_fssd(fssd_r[g]),
        .i_retry(retry_r),
        .i_pulldn_en(pulldn_r[g]),
        .o_drive(drive[g]),
        .o_evt(evt)
      );
      assign ev_open[g] = evt.open_f;
      assign ev_short[g] = evt.short_f;
      assign ev_therm[g] = evt.therm_f;
    end
  endgenerate

  assign fault_set = ev_open | ev_short | ev_therm;

  // ----------------------------------------
  // Status word
  // ----------------------------------------
  // A new fault in the clearing cycle wins, so nothing is lost at the edge
  logic glob_set;

  assign glob_set = |(fault_set | (pins_r.ilim & drive));

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      fault_r <= '0;
    end else if (dev_clear) begin
      fault_r <= '0;
    end else if (cs_rise) begin
      fault_r <= fault_set;
    end else begin
      fault_r <= fault_r | fault_set;
    end
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      glob_r <= 1'b0;
    end else if (dev_clear) begin
      glob_r <= 1'b0;
    end else if (cs_rise) begin
      glob_r <= glob_set;
    end else begin
      glob_r <= glob_r | glob_set;
    end
  end

  always_comb begin
    so_word = '0;
    so_word[fault_sup_pkg::NUM_OUT-1:0] = fault_r;
    so_word[fault_sup_pkg::GLOBAL_FAULT_BIT] = glob_r;
  end

  // ----------------------------------------
  // Interrupts
  // ----------------------------------------
  always_comb begin
    irq_set = '0;
    irq_set[fault_sup_pkg::IRQ_OPEN] = |ev_open;
    irq_set[fault_sup_pkg::IRQ_SHORT] = |ev_short;
    irq_set[fault_sup_pkg::IRQ_THERM] = |ev_therm;
    irq_set[fault_sup_pkg::IRQ_UV] = ctrl_clear;
  end

  always_ff @(posedge I_REF_CLK or negedge I_RESET_N) begin
    if (!I_RESET_N) begin
      irq_st_r <= '0;
    end else if (I_RD && I_ADDR == fault_sup_pkg::OFS_IRQ_ST) begin
      irq_st_r <= irq_set;
    end else begin
      irq_st_r <= irq_st_r | irq_set;
    end
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign O_RDATA = rdata_r;
  assign O_SWITCH_OUTPUTS = drive;
  assign O_PULLDN_EN = pulldn_r;
  assign O_STATUS_WORD = so_word;
  assign O_IRQ = |(irq_st_r & mask_r);

  // ----------------------------------------
  // Checks
  // ----------------------------------------
  property p_cs_clear;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (cs_rise && fault_set == '0 && !glob_set) |=> (O_STATUS_WORD == '0);
  endproperty
  a_cs_clear: assert property (p_cs_clear) else $error("status not cleared at chip-select edge");

  property p_filter;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    cs_rise |=> (!filter_done && ev_open == '0) [*8];
  endproperty
  a_filter: assert property (p_filter) else $error("open load seen inside filter");

  property p_latch;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (fault_r[0] && !cs_rise && !dev_clear) |=> fault_r[0];
  endproperty
  a_latch: assert property (p_latch) else $error("fault bit lost before read");

  property p_glob;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (|(ev_short | ev_therm) && !dev_clear) |=> O_STATUS_WORD[fault_sup_pkg::GLOBAL_FAULT_BIT];
  endproperty
  a_glob: assert property (p_glob) else $error("global fault bit not set");

  property p_uv_off;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    pins_r.serial_output_supply_uv |=> (O_SWITCH_OUTPUTS == '0 && O_PULLDN_EN == '0 && !retry_r);
  endproperty
  a_uv_off: assert property (p_uv_off) else $error("undervoltage left outputs or controls");

  property p_main_uv;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    pins_r.main_uv |=> (O_SWITCH_OUTPUTS == '0 && fault_r == '0);
  endproperty
  a_main_uv: assert property (p_main_uv) else $error("main undervoltage did not reset");

  property p_pulldn_hold;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (!ctrl_clear && !(I_WR && I_ADDR == fault_sup_pkg::OFS_PULLDN)) |=> $stable(O_PULLDN_EN);
  endproperty
  a_pulldn_hold: assert property (p_pulldn_hold) else $error("pull-down changed by itself");

  property p_per_out;
    @(posedge I_REF_CLK) disable iff (!I_RESET_N)
    (ev_therm[3] && !dev_clear) |=> O_STATUS_WORD[3];
  endproperty
  a_per_out: assert property (p_per_out) else $error("per-output fault bit missing");

endmodule : output_fault_supervisor

// ==== shared/fault_sup_pkg.sv ====
// Constants, types and register map of the output fault supervisor
package fault_sup_pkg;

  // ----------------------------------------
  // Sizes and timing
  // ----------------------------------------
  localparam int NUM_OUT = 16;
  localparam int CLK_MHZ = 200;
  localparam int FILTER_MIN_US = 100;
  localparam int SHORT_US = 450;
  localparam int FILTER_CYC = FILTER_MIN_US * CLK_MHZ;
  localparam int SHORT_CYC = SHORT_US * CLK_MHZ;
  localparam int CNT_W = 17;
  localparam int ADDR_W = 8;
  localparam int DATA_W = 32;
  localparam int SO_W = 24;

  // ----------------------------------------
  // Register map and fields
  // ----------------------------------------
  localparam logic [ADDR_W-1:0] OFS_PULLDN = 8'h00;
  localparam logic [ADDR_W-1:0] OFS_FSSD = 8'h04;
  localparam logic [ADDR_W-1:0] OFS_GLOBAL = 8'h08;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 8'h0c;
  localparam logic [ADDR_W-1:0] OFS_IRQ_ST = 8'h10;
  localparam logic [ADDR_W-1:0] OFS_IRQ_MASK = 8'h14;
  localparam int RETRY_BIT = 17;
  localparam int GLOBAL_FAULT_BIT = 23;
  localparam int IRQ_W = 4;
  localparam int IRQ_OPEN = 0;
  localparam int IRQ_SHORT = 1;
  localparam int IRQ_THERM = 2;
  localparam int IRQ_UV = 3;
  localparam logic [NUM_OUT-1:0] PULLDN_RST = 16'h0000;
  localparam logic [NUM_OUT-1:0] FSSD_RST = 16'h0000;
  localparam logic RETRY_RST = 1'b0;
  localparam logic [IRQ_W-1:0] MASK_RST = 4'h0;

  // ----------------------------------------
  // Types
  // ----------------------------------------
  typedef struct packed {
    logic cs_n;
    logic serial_output_supply_uv;
    logic main_uv;
    logic [NUM_OUT-1:0] open_cmp;
    logic [NUM_OUT-1:0] vds_high;
    logic [NUM_OUT-1:0] ilim;
    logic [NUM_OUT-1:0] overtemp;
  } pins_t;

  typedef struct packed {
    logic open_f;
    logic short_f;
    logic therm_f;
  } ch_evt_t;

  typedef enum logic [2:0] {
    CH_RUN = 3'b001,
    CH_HOT = 3'b010,
    CH_LOCKED = 3'b100
  } ch_state_t;

endpackage : fault_sup_pkg

// ==== tb/fault_host_model.sv ====
// Host model that frames serial transfers on chip select
`timescale 1ns/1ps
module fault_host_model #(
  parameter int GAP = 40
) (
  input wire logic i_clk,
  input wire logic [fault_sup_pkg::SO_W-1:0] i_status,
  output logic o_cs_n
);
  // ----
  // Frame: 24 link clocks of 125 ns each
  // ----
  initial o_cs_n = 1'b1;
  task automatic xfer(output logic [fault_sup_pkg::SO_W-1:0] st);
    // Spacing beyond the filter so the word read back is already filtered
    repeat (GAP) @(posedge i_clk);
    o_cs_n <= 1'b0;
    @(posedge i_clk);
    // Status word settles after the edge that updates it
    #1;
    st = i_status;
    repeat (24 * 25) @(posedge i_clk);
    o_cs_n <= 1'b1;
  endtask : xfer
endmodule : fault_host_model

// ==== tb/tb_output_fault_supervisor.sv ====
// Self-checking bench for the output fault supervisor
`timescale 1ns/1ps
module tb_output_fault_supervisor;
  // ----
  // Signals
  // ----
  localparam int FC = 20;
  localparam int SC = 30;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic cs_n;
  logic serial_output_supply_uv = 1'b0;
  logic main_uv = 1'b0;
  logic [15:0] cmd = 16'h0, ocmp = 16'h0, vds = 16'h0, ilim = 16'h0, hot = 16'h0;
  logic [7:0] addr = 8'h0;
  logic [31:0] wdata = 32'h0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [31:0] rdata;
  logic [15:0] outs, pden;
  logic [23:0] st, so;
  logic irq;
  int mismatches = 0;
  int n_checks = 0;
  int pd, op, cm, e;
  always #2.5 clk = ~clk;

  output_fault_supervisor #(.FILTER_CYC(FC), .SHORT_CYC(SC)) output_fault_supervisor_inst (
    .I_REF_CLK(clk), .I_RESET_N(rst_n), .I_CS_N(cs_n),
    .I_SERIAL_OUTPUT_SUPPLY_UV(serial_output_supply_uv), .I_MAIN_UV(main_uv),
    .I_CMD_ON(cmd), .I_OPEN_CMP(ocmp), .I_VDS_HIGH(vds), .I_ILIM(ilim), .I_OVERTEMP(hot),
    .I_ADDR(addr), .I_WDATA(wdata), .I_WR(wr), .I_RD(rd), .O_RDATA(rdata),
    .O_SWITCH_OUTPUTS(outs), .O_PULLDN_EN(pden), .O_STATUS_WORD(st), .O_IRQ(irq));
  fault_host_model #(.GAP(FC + 20)) fault_host_model_inst (.i_clk(clk), .i_status(st), .o_cs_n(cs_n));

  // ----
  // Tasks
  // ----
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    n_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", name, exp, seen);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask : cyc
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  task automatic rd_reg(input logic [7:0] a, input logic [31:0] x);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk("rdata", rdata, x);
  endtask : rd_reg
  task automatic drive(input logic [15:0] c, o, v, l, h);
    @(posedge clk);
    cmd <= c;
    ocmp <= o;
    vds <= v;
    ilim <= l;
    hot <= h;
  endtask : drive
  task automatic results();
    $display("checks %0d mismatches %0d", n_checks, mismatches);
    if (mismatches == 0 && n_checks > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask : results

  // ----
  // Watchdog, far beyond the expected run
  // ----
  initial begin
    #60000;
    mismatches++;
    results();
  end

  // ----
  // Scenarios
  // ----
  initial begin
    void'($urandom(32'hfafe1a59));
    repeat (5) @(posedge clk);
    rst_n <= 1'b1;
    cyc(2);
    chk("pulldn", pden, 32'h0);
    rd_reg(8'h00, 32'h0);
    rd_reg(8'h08, 32'h0);
    rd_reg(8'h10, 32'h0);
    rd_reg(8'h3c, 32'h0);
    pd = $urandom | 1;
    op = $urandom | 1;
    cm = $urandom & 32'hfffe;
    e = op & pd & ~cm & 32'hffff;
    wr_reg(8'h00, {16'h0, pd[15:0]});
    wr_reg(8'h3c, 32'hffffffff);
    cyc(1);
    chk("pulldn", pden, pd[15:0]);
    drive(cm[15:0], op[15:0], 16'h0, 16'h0, 16'h0);
    fault_host_model_inst.xfer(so);
    chk("so open", so[15:0], e[15:0]);
    // Comparator still open at the chip-select edge, so the bits are set again there
    cyc(5);
    drive(cm[15:0], 16'h0, 16'h0, 16'h0, 16'h0);
    cyc(5);
    chk("open kept", st[15:0], e[15:0]);
    fault_host_model_inst.xfer(so);
    chk("so kept", so[15:0], e[15:0]);
    drive(cm[15:0], op[15:0], 16'h0, 16'h0, 16'h0);
    cyc(5);
    chk("filtered", st, 32'h0);
    cyc(FC + 8);
    chk("open bits", st[15:0], e[15:0]);
    drive(cm[15:0], 16'h0, 16'h0, 16'h0, 16'h0);
    wr_reg(8'h14, 32'h1);
    cyc(1);
    chk("irq", irq, 32'h1);
    rd_reg(8'h10, 32'h1);
    cyc(1);
    chk("irq clr", irq, 32'h0);
    fault_host_model_inst.xfer(so);
    cyc(5);
    chk("cs clear", st, 32'h0);
    chk("pulldn kept", pden, pd[15:0]);
    // Short on ch5 with fast shutdown, ch6 left to thermal only
    wr_reg(8'h04, 32'h40);
    drive(16'h0060, 16'h0, 16'h0060, 16'h0060, 16'h0);
    cyc(SC / 2);
    chk("short early", outs, 32'h60);
    chk("ilim global", st[23], 32'h1);
    cyc(SC);
    chk("short off", outs, 32'h40);
    chk("short bits", st & 24'h800020, 32'h800020);
    rd_reg(8'h10, 32'h2);
    drive(16'h0, 16'h0, 16'h0, 16'h0, 16'h0);
    fault_host_model_inst.xfer(so);
    cyc(5);
    drive(16'hffff, 16'h0, 16'h0, 16'h0, 16'h0008);
    cyc(6);
    chk("hot off", outs, 32'hfff7);
    chk("hot bits", st & 24'h800008, 32'h800008);
    drive(16'hffff, 16'h0, 16'h0, 16'h0, 16'h0);
    cyc(6);
    chk("locked", outs, 32'hfff7);
    wr_reg(8'h08, 32'h20000);
    drive(16'hffff, 16'h0, 16'h0, 16'h0, 16'h0200);
    cyc(6);
    chk("retry off", outs | 16'h8, 32'hfdff);
    drive(16'hffff, 16'h0, 16'h0, 16'h0, 16'h0);
    cyc(6);
    chk("retry on", outs | 16'h8, 32'hffff);
    @(posedge clk) serial_output_supply_uv <= 1'b1;
    cyc(6);
    chk("uv outs", outs, 32'h0);
    @(posedge clk) serial_output_supply_uv <= 1'b0;
    cyc(4);
    rd_reg(8'h04, 32'h0);
    rd_reg(8'h08, 32'h0);
    chk("uv pulldn", pden, 32'h0);
    @(posedge clk) main_uv <= 1'b1;
    cyc(6);
    chk("main uv st", st, 32'h0);
    chk("main uv outs", outs, 32'h0);
    @(posedge clk) main_uv <= 1'b0;
    cyc(4);
    results();
  end
endmodule : tb_output_fault_supervisor
